// ---- pss_start_sel.sv ----
// Positioning start selector: picks which stored entry runs, and when
`timescale 1ns/1ps
module pss_start_sel #(
    parameter int LINES  = pss_pkg::NUM_LINES,
    parameter int SEL_W  = pss_pkg::SEL_W
) (
    input  wire logic                    core_clk_in,
    input  wire logic                    reset_in,
    input  wire logic [SEL_W-1:0]        data_select_in,
    input  wire logic                    start_in,
    input  wire logic [LINES-1:0]        direct_launch_line_in,
    input  wire logic                    sequence_advance_input_in,
    input  wire logic                    move_done_in,
    input  wire logic                    seq_clear_in,
    input  wire logic                    map_wr_en_in,
    input  wire logic [2:0]              map_wr_line_in,
    input  wire logic [SEL_W-1:0]        map_wr_entry_in,
    input  wire logic                    flag_wr_en_in,
    input  wire logic [SEL_W-1:0]        flag_wr_addr_in,
    input  wire logic                    flag_wr_data_in,
    output logic                         ready_out,
    output logic                         launch_out,
    output logic [SEL_W-1:0]             entry_out,
    output logic [pss_pkg::CUR_W-1:0]    current_entry_out,
    output logic [SEL_W-1:0]             seq_start_out
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pss_pkg::pss_state_t         state_q;
    pss_pkg::pss_state_t         state_d;
    logic                        start_prev_q;
    logic                        adv_prev_q;
    logic [LINES-1:0]            line_prev_q;
    logic [SEL_W-1:0]            map_q [LINES];
    logic [pss_pkg::CUR_W-1:0]   cur_q;
    logic [SEL_W-1:0]            seq_start_q;
    logic                        launch_q;
    logic [SEL_W-1:0]            entry_q;
    logic                        next_flag;
    logic                        ready_q;

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    wire               start_rise;
    wire               adv_rise;
    wire [LINES-1:0]   line_rise;
    wire               idle;
    assign start_rise = start_in & ~start_prev_q;
    assign adv_rise   = sequence_advance_input_in & ~adv_prev_q;
    assign line_rise  = direct_launch_line_in & ~line_prev_q;
    assign idle       = (state_q == pss_pkg::PSS_IDLE);

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            start_prev_q <= 1'h0;
            adv_prev_q   <= 1'h0;
            line_prev_q  <= '0;
        end else begin
            start_prev_q <= start_in;
            adv_prev_q   <= sequence_advance_input_in;
            line_prev_q  <= direct_launch_line_in;
        end
    end

    // ------------------------------------------------------------
    // Direct line selection
    // ------------------------------------------------------------
    logic              line_any;
    logic [SEL_W-1:0]  line_entry;
    always_comb begin
        line_any   = 1'h0;
        line_entry = '0;
        for (int k = LINES - 1; k >= 0; k--) begin
            if (line_rise[k]) begin
                line_any   = 1'h1;
                line_entry = map_q[k];
            end
        end
    end

    // map registers, line k resets to k
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            for (int k = 0; k < LINES; k++) begin
                map_q[k] <= SEL_W'(k);
            end
        end else if (map_wr_en_in && (int'(map_wr_line_in) < LINES)) begin
            map_q[map_wr_line_in] <= map_wr_entry_in;
        end
    end

    // ------------------------------------------------------------
    // Sequence lookup
    // ------------------------------------------------------------
    wire               cur_none;
    wire               cur_last;
    wire [SEL_W-1:0]   next_addr;
    wire [SEL_W-1:0]   seq_entry;
    assign cur_none  = (cur_q == pss_pkg::CUR_NONE);
    assign cur_last  = (cur_q[SEL_W-1:0] == pss_pkg::LAST_ENTRY);
    assign next_addr = cur_q[SEL_W-1:0] + 6'h01;
    // disabled next entry falls back to start
    assign seq_entry = (cur_none || cur_last || !next_flag)
                     ? seq_start_q : next_addr;

    pss_flag_mem #(
        .DEPTH  (pss_pkg::NUM_ENTRIES),
        .ADDR_W (SEL_W)
    ) u_flags (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .wr_en_in    (flag_wr_en_in),
        .wr_addr_in  (flag_wr_addr_in),
        .wr_data_in  (flag_wr_data_in),
        .rd_addr_in  (next_addr),
        .rd_data_out (next_flag)
    );

    // ------------------------------------------------------------
    // Launch decision
    // ------------------------------------------------------------
    wire   sel_go;
    wire   line_go;
    wire   seq_go;
    // start wins, then direct, then advance
    assign sel_go  = idle & start_rise;
    assign line_go = idle & ~start_rise & line_any;
    assign seq_go  = idle & ~start_rise & ~line_any & adv_rise;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pss_pkg::PSS_IDLE: begin
                if (sel_go || line_go) begin
                    state_d = pss_pkg::PSS_BUSY;
                end else if (seq_go) begin
                    state_d = pss_pkg::PSS_SEQ_RD;
                end
            end
            pss_pkg::PSS_SEQ_RD:  state_d = pss_pkg::PSS_SEQ_DEC;
            pss_pkg::PSS_SEQ_DEC: state_d = pss_pkg::PSS_BUSY;
            pss_pkg::PSS_BUSY: begin
                if (move_done_in) begin
                    state_d = pss_pkg::PSS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            state_q <= pss_pkg::PSS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Launch outputs and pointers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            launch_q    <= 1'h0;
            entry_q     <= '0;
            cur_q       <= pss_pkg::CUR_NONE;
            seq_start_q <= pss_pkg::SEQ_START_RST;
        end else begin
            launch_q <= 1'h0;
            if (sel_go) begin
                launch_q    <= 1'h1;
                entry_q     <= data_select_in;
                cur_q       <= {1'h0, data_select_in};
                seq_start_q <= data_select_in;
            end else if (line_go) begin
                launch_q    <= 1'h1;
                entry_q     <= line_entry;
                cur_q       <= {1'h0, line_entry};
                seq_start_q <= line_entry;
            end else if (state_q == pss_pkg::PSS_SEQ_DEC) begin
                launch_q <= 1'h1;
                entry_q  <= seq_entry;
                cur_q    <= {1'h0, seq_entry};
            end
            if (seq_clear_in) begin
                cur_q       <= pss_pkg::CUR_NONE;
                seq_start_q <= pss_pkg::SEQ_START_RST;
            end
        end
    end

    // ready low from launch request until done
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ready_q <= 1'h1;
        end else begin
            ready_q <= (state_d == pss_pkg::PSS_IDLE);
        end
    end

    assign ready_out         = ready_q;
    assign launch_out        = launch_q;
    assign entry_out         = entry_q;
    assign current_entry_out = cur_q;
    assign seq_start_out     = seq_start_q;
endmodule // pss_start_sel

// ---- pss_flag_mem.sv ----
// Shared constants and the per-entry sequential flag memory
`timescale 1ns/1ps
package pss_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_LINES   = 6;
    localparam int SEL_W       = 6;
    localparam int NUM_ENTRIES = 64;
    localparam int CUR_W       = 7;
    // ------------------------------------------------------------
    // Reset values and last entry index
    // ------------------------------------------------------------
    localparam logic [CUR_W-1:0] CUR_NONE      = 7'h7f;
    localparam logic [SEL_W-1:0] SEQ_START_RST = 6'h00;
    localparam logic [SEL_W-1:0] LAST_ENTRY    = 6'h3f;
    localparam logic             FLAG_RST      = 1'h0;
    // ------------------------------------------------------------
    // Launch state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSS_IDLE    = 2'h0,
        PSS_SEQ_RD  = 2'h1,
        PSS_SEQ_DEC = 2'h3,
        PSS_BUSY    = 2'h2
    } pss_state_t;
endpackage

module pss_flag_mem #(
    parameter int DEPTH  = pss_pkg::NUM_ENTRIES,
    parameter int ADDR_W = pss_pkg::SEL_W
) (
    input  wire logic              core_clk_in,
    input  wire logic              reset_in,
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic              wr_data_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic                   rd_data_out
);
    logic [DEPTH-1:0] flag_q;

    // one flag per entry, disabled at reset
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            flag_q <= {DEPTH{pss_pkg::FLAG_RST}};
        end else if (wr_en_in) begin
            flag_q[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rd_data_out <= pss_pkg::FLAG_RST;
        end else begin
            rd_data_out <= flag_q[rd_addr_in];
        end
    end
endmodule // pss_flag_mem

// ---- pss_start_sel_props.sv ----
// Concurrent checks on the start selector ports
`timescale 1ns/1ps
module pss_props (
    input wire logic       core_clk_in,
    input wire logic       reset_in,
    input wire logic [5:0] data_select_in,
    input wire logic       start_in,
    input wire logic [5:0] direct_launch_line_in,
    input wire logic       sequence_advance_input_in,
    input wire logic       move_done_in,
    input wire logic       seq_clear_in,
    input wire logic       ready_out,
    input wire logic       launch_out,
    input wire logic [5:0] entry_out,
    input wire logic [6:0] current_entry_out,
    input wire logic [5:0] seq_start_out
);
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (reset_in);
    sequence s_adv;
        ready_out && $rose(sequence_advance_input_in) && !$rose(start_in)
        && $stable(direct_launch_line_in);
    endsequence
    sequence s_look;
        (!ready_out && !launch_out) [*2] ##1 launch_out;
    endsequence
    property p_start;
        ready_out && $rose(start_in) |=> launch_out && !ready_out
        && entry_out == $past(data_select_in);
    endproperty
    a_start: assert property (p_start) else $error("start launch");
    property p_direct;
        ready_out && !$rose(start_in) && !seq_clear_in
        && $rose(direct_launch_line_in[0])
        |=> launch_out && seq_start_out == entry_out;
    endproperty
    a_direct: assert property (p_direct) else $error("direct");
    property p_adv; s_adv |=> s_look; endproperty
    a_adv: assert property (p_adv) else $error("advance timing");
    property p_gate; launch_out |-> $past(ready_out) || $past(ready_out, 3);
    endproperty
    a_gate: assert property (p_gate) else $error("launch not ready");
    property p_done;
        !ready_out && move_done_in && !$past(ready_out)
        && !$past(ready_out, 2) |=> ready_out;
    endproperty
    a_done: assert property (p_done) else $error("ready not back");
    property p_rdy; $rose(ready_out) |-> $past(move_done_in); endproperty
    a_rdy: assert property (p_rdy) else $error("ready early");
    property p_clear; seq_clear_in |=> seq_start_out == 6'h00
        && current_entry_out == pss_pkg::CUR_NONE; endproperty
    a_clear: assert property (p_clear) else $error("clear");
    property p_cur; launch_out && !$past(seq_clear_in)
        |-> current_entry_out == {1'b0, entry_out}; endproperty
    a_cur: assert property (p_cur) else $error("current entry");
endmodule // pss_props
bind pss_start_sel pss_props u_props (.*);

// ---- pss_host_model.sv ----
// Host controller model driving the launch inputs
`timescale 1ns/1ps
module pss_host_model (
    input  wire logic       core_clk_in,
    input  wire logic       ready_in,
    input  wire logic       go_in,
    input  wire logic [1:0] kind_in,
    input  wire logic [5:0] val_in,
    output logic [5:0]      sel_out,
    output logic            start_out,
    output logic [5:0]      line_out,
    output logic            adv_out,
    output logic            done_out
);
    int i;
    initial begin
        {sel_out, start_out, line_out, adv_out, done_out} = 15'h0000;
    end
    always @(negedge core_clk_in) begin
        if (go_in) begin
            for (i = 0; i < 40 && ready_in !== 1'b1; i++)
                @(negedge core_clk_in);
            sel_out = val_in;
            if (kind_in != 2'h3)
                @(negedge core_clk_in);
            start_out = kind_in[0];
            adv_out = kind_in == 2'h2;
            line_out = kind_in == 2'h0 ? 6'h01 << val_in[2:0] : 6'h00;
            for (i = 0; i < 40 && ready_in !== 1'b0; i++)
                @(negedge core_clk_in);
            {start_out, line_out, adv_out} = 8'h00;
            sel_out = ~val_in;
            repeat (3) @(negedge core_clk_in);
            done_out = 1'b1;
            @(negedge core_clk_in);
            done_out = 1'b0;
        end
    end
endmodule // pss_host_model

// ---- tb_pss_start_sel.sv ----
// Self-checking bench for the positioning start selector
`timescale 1ns/1ps
module tb_pss_start_sel;
    logic       clk = 1'b0, rst = 1'b1, go = 1'b0, clr = 1'b0, st, adv;
    logic       done, m_en = 1'b0, f_en = 1'b0, f_d = 1'b0, rdy, lch;
    logic [1:0] kind = 2'h0;
    logic [2:0] m_ln = 3'h0;
    logic [5:0] val = 6'h00, sel, ln, m_e = 6'h00, f_a = 6'h00, ent, ss;
    logic [6:0] cur;
    int         failures = 0, n_checks = 0;
    initial forever #50 clk = ~clk;
    pss_start_sel DUT (.core_clk_in(clk), .reset_in(rst),
        .data_select_in(sel), .start_in(st), .direct_launch_line_in(ln),
        .sequence_advance_input_in(adv), .move_done_in(done),
        .seq_clear_in(clr), .map_wr_en_in(m_en), .map_wr_line_in(m_ln),
        .map_wr_entry_in(m_e), .flag_wr_en_in(f_en), .flag_wr_addr_in(f_a),
        .flag_wr_data_in(f_d), .ready_out(rdy), .launch_out(lch),
        .entry_out(ent), .current_entry_out(cur), .seq_start_out(ss));
    pss_host_model u_host (.core_clk_in(clk), .ready_in(rdy), .go_in(go),
        .kind_in(kind), .val_in(val), .sel_out(sel), .start_out(st),
        .line_out(ln), .adv_out(adv), .done_out(done));
    task automatic check(input string nm, input logic [6:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic run(input logic [1:0] k, input logic [5:0] v, e);
        int i;
        int j;
        kind <= k;
        val <= v;
        go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        for (i = 0; i < 40 && lch !== 1'b1; i++) @(negedge clk);
        check("entry", {1'b0, ent}, {1'b0, e});
        check("ready", {6'h00, rdy}, 7'h00);
        for (j = 0; j < 40 && rdy !== 1'b1; j++) @(negedge clk);
        if (i == 40 || j == 40) begin
            failures++;
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic map, input logic [5:0] a, e);
        m_ln <= a[2:0];
        m_e <= e;
        f_a <= a;
        f_d <= e[0];
        m_en <= map;
        f_en <= !map;
        @(negedge clk);
        m_en <= 1'b0;
        f_en <= 1'b0;
    endtask
    task automatic t_select;
        check("current", cur, pss_pkg::CUR_NONE);
        run(2'h1, 6'h05, 6'h05);
        check("seq start", {1'b0, ss}, 7'h05);
        run(2'h3, 6'h3f, 6'h3f);
        $display("test select done");
    endtask
    task automatic t_direct;
        for (int k = 0; k < 6; k++)
            run(2'h0, k[5:0], k[5:0]);
        wr(1'b1, 6'h00, 6'h28);
        run(2'h0, 6'h00, 6'h28);
        $display("test direct done");
    endtask
    task automatic t_seq;
        wr(1'b0, 6'h29, 6'h01);
        wr(1'b0, 6'h2a, 6'h01);
        run(2'h2, 6'h00, 6'h29);
        run(2'h2, 6'h00, 6'h2a);
        run(2'h2, 6'h00, 6'h28);
        check("seq start", {1'b0, ss}, 7'h28);
        $display("test sequence done");
    endtask
    task automatic t_clear;
        clr <= 1'b1;
        @(negedge clk);
        clr <= 1'b0;
        check("current", cur, 7'h7f);
        check("seq start", {1'b0, ss}, 7'h00);
        run(2'h2, 6'h00, 6'h00);
        $display("test clear done");
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_select();
        t_direct();
        t_seq();
        t_clear();
        tally_and_finish();
    end
endmodule // tb_pss_start_sel
